// File: rtl/pwm_fault_pkg.sv
/*
 Shared constants for the modulator protection and sync block.
 Assumes a single 50 MHz clock and synchronous active-high reset.
*/
// Functional notes
// R1: Count current-limit hits per switching period
// R2: Sample current-limit at compensator event two
// R3: Eight-bit maximum count before flag
// R4: Non-continuous mode clears count on clean cycle
// R5: Continuous mode accumulates until maximum reached
// R6: Current-limit flag goes out to processor
// R7: Flag forces modulator outputs inactive directly
// R8: Comparator A-D selects current-limit source
// R9: Per-output pin override with value bit
// R10: Pin levels readable as status
// R11: Fault enable turns outputs off
// R12: Fault pins latched, sent to processor
// R13: Normal mode: either fault kills both
// R14: Other modes: fault0 to A, fault1 to B
// R15: Resume switching at new period start
// R16: Two-bit compensator select per modulator
// R17: Resonant mode binds compensator n to n
// R18: Sync slave resets counter on trigger
// R19: Channel-select bits pick master trigger
// R20: Remote sync follows external pin
// R21: Sync output divides switching period
// R22: Software enables sync pin as output
// R23: Flag sticky until cleared; counter zero disabled
package pwm_fault_pkg;
	localparam int CNT_W       = 8;        // Trip count width
	localparam int SEL_W       = 2;        // Selector width
	localparam int DIV_W       = 8;        // Sync divider width
	localparam logic [7:0] CNT_RST = 8'h00; // Counter reset value
	localparam logic [1:0] SEL_RST = 2'h0;  // Selector reset value

	// Modulator operating modes
	typedef enum logic [1:0] {
		MODE_NORMAL    = 2'b00,
		MODE_MULTI_OUT = 2'b01,
		MODE_RESONANT  = 2'b10,
		MODE_PHASE     = 2'b11
	} pwm_mode_t;
endpackage

// File: rtl/trip_counter.sv
/*
 Current-limit trip counter with sticky flag.
 Assumes a sample strobe once per switching period.
*/
`timescale 1ns/1ps
module trip_counter #(
	parameter int W = pwm_fault_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	// Control
	input  wire logic         i_enable,
	input  wire logic         i_continuous,
	input  wire logic [W-1:0] i_max_count,
	input  wire logic         i_flag_clear,
	// Sample
	input  wire logic         i_sample,
	input  wire logic         i_limit,
	// Status
	output logic              o_flag,
	output logic [W-1:0]      o_count
);
	import pwm_fault_pkg::*;

	logic [W-1:0] next_count;  // Next counter value
	wire          hit;         // Indication seen at sample
	wire          miss;        // Clean cycle at sample
	wire          reach;       // Maximum count reached

	assign hit   = i_sample & i_limit;          // [R1] [R2]
	assign miss  = i_sample & ~i_limit;
	assign reach = hit & ((o_count + 1'b1) >= i_max_count); // [R3] [R5]

	// Counter next value; saturates so a long fault cannot wrap
	always_comb begin
		next_count = o_count;
		if (!i_enable) begin
			next_count = W'(CNT_RST);                // [R23]
		end else if (hit && o_count != {W{1'b1}}) begin
			next_count = o_count + 1'b1;             // [R1]
		end else if (miss && !i_continuous) begin
			next_count = W'(CNT_RST);                // [R4]
		end
	end

	// Count register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_count <= W'(CNT_RST);
		else o_count <= next_count;
	end

	// Sticky flag; a new trip wins over a clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_flag <= 1'b0;
		else if (i_enable && reach) o_flag <= 1'b1;   // [R23] [R6]
		else if (i_flag_clear) o_flag <= 1'b0;
	end

	a_count_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_enable |=> o_count == '0) else $error("count not held at zero"); // [R23]
	a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_flag && !i_flag_clear |=> o_flag) else $error("flag dropped"); // [R23]
	a_clean_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_enable && miss && !i_continuous |=> o_count == '0) else $error("no reset"); // [R4]
	a_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_enable && reach |=> o_flag) else $error("flag not set"); // [R5]
	c_trip: cover property (@(posedge i_clk) $rose(o_flag));
endmodule

// File: rtl/sync_divider.sv
/*
 Sync-output divider: one pulse each N+1 switching periods.
 Assumes a one-cycle period-start strobe.
*/
`timescale 1ns/1ps
module sync_divider #(
	parameter int W = pwm_fault_pkg::DIV_W
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	// Control
	input  wire logic [W-1:0] i_ratio,
	input  wire logic         i_period_start,
	// Output
	output logic              o_pulse
);
	import pwm_fault_pkg::*;

	logic [W-1:0] cnt;   // Periods seen since last pulse
	wire          wrap;  // Divider terminal

	assign wrap = i_period_start && (cnt >= i_ratio);  // [R21]

	// Period counter
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) cnt <= '0;
		else if (wrap) cnt <= '0;
		else if (i_period_start) cnt <= cnt + 1'b1;
	end

	// Registered pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_pulse <= 1'b0;
		else o_pulse <= wrap;
	end

	a_sync_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		wrap |=> o_pulse) else $error("sync pulse missing"); // [R21]
	c_sync: cover property (@(posedge i_clk) o_pulse);
endmodule

// File: rtl/pwm_fault_sync_control.sv
/*
 Protection, override and sync control around one modulator channel.
 Assumes modulator core supplies raw outputs, period start and event strobe;
 all inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
module pwm_fault_sync_control (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_sys_rst,
	// Modulator core
	input  wire logic                      i_mod_a,
	input  wire logic                      i_mod_b,
	input  wire logic                      i_period_start,
	input  wire logic                      i_cmp_event2,
	input  wire pwm_fault_pkg::pwm_mode_t  i_mode,
	// Current limit
	input  wire logic                      i_trip_enable,
	input  wire logic                      i_trip_continuous,
	input  wire logic [7:0]                i_trip_max,
	input  wire logic                      i_trip_clear,
	input  wire logic [1:0]                i_cmp_select,
	input  wire logic [3:0]                i_comparators,
	// Pin override
	input  wire logic                      i_gpio_en_a,
	input  wire logic                      i_gpio_en_b,
	input  wire logic                      i_gpio_val_a,
	input  wire logic                      i_gpio_val_b,
	// External faults
	input  wire logic                      i_fault_enable,
	input  wire logic [1:0]                i_fault_pins,
	input  wire logic [1:0]                i_fault_clear,
	// Compensator selection
	input  wire logic [1:0]                i_comp_select,
	input  wire logic [1:0]                i_channel_index,
	// Sync
	input  wire logic                      i_sync_slave_en,
	input  wire logic [1:0]                i_sync_chan_sel,
	input  wire logic [3:0]                i_master_triggers,
	input  wire logic                      i_remote_sync_en,
	input  wire logic                      i_remote_sync_pin,
	input  wire logic [7:0]                i_sync_div_ratio,
	input  wire logic                      i_sync_out_en,
	// Outputs
	output logic                           o_pin_a,
	output logic                           o_pin_b,
	output logic [1:0]                     o_pin_status,
	output logic                           o_trip_flag,
	output logic [7:0]                     o_trip_count,
	output logic [1:0]                     o_fault_latched,
	output logic [1:0]                     o_comp_route,
	output logic                           o_counter_reset,
	output logic                           o_sync_out
);
	import pwm_fault_pkg::*;

	// Selected comparator as the current-limit indication
	wire       limit_src = i_comparators[i_cmp_select];  // [R8]
	wire       sync_pulse;                               // Divider output
	logic [1:0] fault;                                   // Latched fault pins
	logic [1:0] held;                                    // Output held off until period start
	wire [1:0] fault_kill;                               // Fault shutdown per output
	wire       trip_kill;                                // Current-limit shutdown
	wire       master_hit;                               // Chosen master trigger
	logic      remote_d;                                 // Remote sync previous level
	wire       remote_edge;                              // Remote sync rising edge
	wire       out_a;                                    // Gated modulator A
	wire       out_b;                                    // Gated modulator B

	trip_counter #(.W(CNT_W)) u_trip (
		.i_clk        (i_clk),
		.i_sys_rst    (i_sys_rst),
		.i_enable     (i_trip_enable),
		.i_continuous (i_trip_continuous),
		.i_max_count  (i_trip_max),
		.i_flag_clear (i_trip_clear),
		.i_sample     (i_cmp_event2),     // [R2]
		.i_limit      (limit_src),
		.o_flag       (o_trip_flag),      // [R6]
		.o_count      (o_trip_count)
	);

	sync_divider #(.W(DIV_W)) u_sync (
		.i_clk          (i_clk),
		.i_sys_rst      (i_sys_rst),
		.i_ratio        (i_sync_div_ratio),
		.i_period_start (i_period_start),
		.o_pulse        (sync_pulse)
	);

	// Fault latch: pin set wins over software clear
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) fault <= 2'h0;
		else fault <= i_fault_pins | (fault & ~i_fault_clear);  // [R12]
	end

	// Fault routing by mode
	assign fault_kill = !i_fault_enable ? 2'b00 :
		(i_mode == MODE_NORMAL) ? {2{|fault}} : fault;  // [R11] [R13] [R14]

	// Shutdown held until next period start once fault goes away
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) held <= 2'b00;
		else held <= fault_kill | (held & {2{~i_period_start}});  // [R15]
	end

	assign trip_kill = o_trip_flag;                                    // [R7]
	assign out_a = i_mod_a & ~trip_kill & ~fault_kill[0] & ~held[0];
	assign out_b = i_mod_b & ~trip_kill & ~fault_kill[1] & ~held[1];

	// Pin drive with override
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pin_a <= 1'b0;
			o_pin_b <= 1'b0;
		end else begin
			o_pin_a <= i_gpio_en_a ? i_gpio_val_a : out_a;  // [R9]
			o_pin_b <= i_gpio_en_b ? i_gpio_val_b : out_b;  // [R9]
		end
	end

	// Status readback of pin levels, one cycle behind the pins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_pin_status <= 2'b00;
		else o_pin_status <= {o_pin_b, o_pin_a};  // [R10]
	end

	assign o_fault_latched = fault;  // [R12]

	// Compensator routing; resonant mode forces own index
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_comp_route <= SEL_RST;
		else if (i_mode == MODE_RESONANT) o_comp_route <= i_channel_index;  // [R17]
		else o_comp_route <= i_comp_select;                                // [R16]
	end

	// Sync sources
	assign master_hit  = i_sync_slave_en & i_master_triggers[i_sync_chan_sel]; // [R18] [R19]
	assign remote_edge = i_remote_sync_en & i_remote_sync_pin & ~remote_d;     // [R20]

	// Remote pin edge history
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) remote_d <= 1'b0;
		else remote_d <= i_remote_sync_pin;
	end

	// Counter reset request and sync output
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_counter_reset <= 1'b0;
			o_sync_out      <= 1'b0;
		end else begin
			o_counter_reset <= master_hit | remote_edge;   // [R18] [R20]
			o_sync_out      <= sync_pulse & i_sync_out_en; // [R22]
		end
	end

	a_trip_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_trip_flag && !i_gpio_en_a |=> !o_pin_a) else $error("trip not off"); // [R7]
	a_normal_fault: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_fault_enable && i_mode == MODE_NORMAL && |fault && !i_gpio_en_b
		|=> !o_pin_b) else $error("fault not off"); // [R13]
	a_gpio_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_gpio_en_a |=> o_pin_a == $past(i_gpio_val_a)) else $error("gpio"); // [R9]
	a_resonant_bind: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_mode == MODE_RESONANT |=> o_comp_route == $past(i_channel_index))
		else $error("route"); // [R17]
	a_slave_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		master_hit |=> o_counter_reset) else $error("no slave reset"); // [R18]
	a_fault_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_fault_pins[0] |=> fault[0]) else $error("fault not latched"); // [R12]
	c_fault: cover property (@(posedge i_clk) $fell(held[0]));
	c_remote: cover property (@(posedge i_clk) remote_edge);
endmodule

// File: testbench/fault_source_model.sv
/*
 Far-side model: the comparator bank and the two external fault pins.
 Assumes the bench sets the wanted levels just after a falling clock edge.
*/
`timescale 1ns/1ps
module fault_source_model (
	// Requests from the bench
	input  wire logic       i_hit,
	input  wire logic [1:0] i_hit_idx,
	input  wire logic [1:0] i_fault_req,
	// Lines into the block
	output logic [3:0]      o_comparators,
	output logic [1:0]      o_fault_pins
);
	// Unselected comparators show the opposite level, so a wrong select reads the inverted hit
	always_comb begin
		o_comparators = {4{~i_hit}};
		o_comparators[i_hit_idx] = i_hit;
	end
	// Fault pins are high for as long as a fault stands
	assign o_fault_pins = i_fault_req;
endmodule

// File: testbench/pwm_fault_sync_control_bench.sv
/*
 Self-checking bench for the protection, override and sync block.
 Assumes registered outputs one cycle after their cause; inputs move at negedge.
*/
`timescale 1ns/1ps
module pwm_fault_sync_control_bench;
	import pwm_fault_pkg::*;
	logic       clk = 1'b0, rst = 1'b1;          // Clock and reset
	logic       ma = 1'b0, mb = 1'b0, ps = 1'b0; // Raw outputs, period start
	logic       ev = 1'b0, hit = 1'b0;           // Sample strobe, comparator level
	pwm_mode_t  mode = MODE_NORMAL;              // Operating mode
	logic       ten = 1'b0, tcont = 1'b0, tclr = 1'b0;
	logic [7:0] tmax = 8'h03, ratio = 8'h00;
	logic [1:0] csel = 2'h0, fault = 2'h0, fclr = 2'h0, comp = 2'h0, chan = 2'h0;
	logic       gea = 1'b0, geb = 1'b0, gva = 1'b0, gvb = 1'b0, fen = 1'b0;
	logic       sen = 1'b0, ren = 1'b0, rpin = 1'b0, soe = 1'b0;
	logic [1:0] ssel = 2'h0;
	logic [3:0] mtrig = 4'h0, comps;
	logic [1:0] fpins, pstat, flat, route;       // Far-side lines and outputs
	logic       pa, pb, tflag, crst, sout;
	logic [7:0] tcount;
	int         fail_count = 0, cmp_count = 0, k, n;

	fault_source_model src_u (.i_hit(hit), .i_hit_idx(csel), .i_fault_req(fault),
		.o_comparators(comps), .o_fault_pins(fpins));

	pwm_fault_sync_control dut_u (.i_clk(clk), .i_sys_rst(rst), .i_mod_a(ma), .i_mod_b(mb),
		.i_period_start(ps), .i_cmp_event2(ev), .i_mode(mode), .i_trip_enable(ten),
		.i_trip_continuous(tcont), .i_trip_max(tmax), .i_trip_clear(tclr),
		.i_cmp_select(csel), .i_comparators(comps), .i_gpio_en_a(gea), .i_gpio_en_b(geb),
		.i_gpio_val_a(gva), .i_gpio_val_b(gvb), .i_fault_enable(fen), .i_fault_pins(fpins),
		.i_fault_clear(fclr), .i_comp_select(comp), .i_channel_index(chan),
		.i_sync_slave_en(sen), .i_sync_chan_sel(ssel), .i_master_triggers(mtrig),
		.i_remote_sync_en(ren), .i_remote_sync_pin(rpin), .i_sync_div_ratio(ratio),
		.i_sync_out_en(soe), .o_pin_a(pa), .o_pin_b(pb), .o_pin_status(pstat),
		.o_trip_flag(tflag), .o_trip_count(tcount), .o_fault_latched(flat),
		.o_comp_route(route), .o_counter_reset(crst), .o_sync_out(sout));

	// Free-running 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	// Step to the falling edge, where inputs change and outputs are settled
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask

	// Case-equality compare so an unknown never matches
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One sample strobe with the selected comparator at level h
	task automatic sample(input logic h);
		hit = h;
		ev = 1'b1;
		cyc(1);
		ev = 1'b0;
	endtask

	// Verdict and end of run
	task automatic end_sim;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs only a few microseconds
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial begin
		cyc(12);
		rst = 1'b0;
		cyc(1);
		chk(8'({pa, pb, tflag, crst, sout}), 8'h00);
		chk(tcount, 8'h00);
		ten = 1'b1;
		ma = 1'b1;
		mb = 1'b1;
		// Consecutive counting from every comparator in turn
		for (k = 0; k < 4; k++) begin
			csel = 2'(k);
			sample(1'b1);
			sample(1'b1);
			chk(tcount, 8'h02);
			chk(8'(tflag), 8'h00);
			sample(1'b0);
			chk(tcount, 8'h00);
			hit = 1'b1;
			cyc(2);
			chk(tcount, 8'h00);
			repeat (3) sample(1'b1);
			chk(8'(tflag), 8'h01);
			cyc(1);
			chk(8'({pa, pb}), 8'h00);
			sample(1'b0);
			chk(8'(tflag), 8'h01);
			tclr = 1'b1;
			cyc(1);
			tclr = 1'b0;
			chk(8'(tflag), 8'h00);
		end
		// Accumulating mode keeps the count across clean cycles
		tcont = 1'b1;
		tmax = 8'h04;
		sample(1'b1);
		sample(1'b0);
		sample(1'b1);
		sample(1'b0);
		chk(tcount, 8'h02);
		sample(1'b1);
		chk(8'(tflag), 8'h00);
		sample(1'b1);
		chk(8'(tflag), 8'h01);
		ten = 1'b0;
		sample(1'b1);
		chk(tcount, 8'h00);
		tclr = 1'b1;
		tcont = 1'b0;
		cyc(1);
		tclr = 1'b0;
		// Pin override and status readback
		gea = 1'b1;
		cyc(1);
		chk(8'(pa), 8'h00);
		gva = 1'b1;
		geb = 1'b1;
		cyc(2);
		chk(8'({pa, pb}), 8'h02);
		chk(8'(pstat), 8'h01);
		gea = 1'b0;
		geb = 1'b0;
		// Faults with the enable low must leave the outputs switching
		fault = 2'b11;
		cyc(2);
		chk(8'({pa, pb}), 8'h03);
		fault = 2'b00;
		fclr = 2'b11;
		cyc(1);
		fclr = 2'b00;
		// Fault routing per mode, then resume only at a period start
		fen = 1'b1;
		for (k = 0; k < 4; k++) begin
			mode = pwm_mode_t'(k);
			fault = (k == 1) ? 2'b01 : 2'b10;
			n = (k == 0) ? 0 : int'(fault);
			cyc(2);
			chk(8'(flat), 8'(fault));
			chk(8'({pa, pb}), 8'(n));
			fault = 2'b00;
			fclr = 2'b11;
			cyc(1);
			fclr = 2'b00;
			cyc(2);
			chk(8'(flat), 8'h00);
			chk(8'({pa, pb}), 8'(n));
			ps = 1'b1;
			cyc(1);
			ps = 1'b0;
			cyc(2);
			chk(8'({pa, pb}), 8'h03);
		end
		// Compensator select, then the fixed resonant binding
		mode = MODE_NORMAL;
		chan = 2'b01;
		for (k = 0; k < 4; k++) begin
			comp = 2'(k);
			cyc(2);
			chk(8'(route), 8'(k));
		end
		mode = MODE_RESONANT;
		cyc(2);
		chk(8'(route), 8'h01);
		// Internal sync follows only the chosen master trigger
		sen = 1'b1;
		ssel = 2'b10;
		mtrig = 4'b0100;
		cyc(1);
		mtrig = 4'b1011;
		chk(8'(crst), 8'h01);
		cyc(1);
		mtrig = 4'h0;
		chk(8'(crst), 8'h00);
		sen = 1'b0;
		ren = 1'b1;
		rpin = 1'b1;
		cyc(1);
		chk(8'(crst), 8'h01);
		cyc(1);
		chk(8'(crst), 8'h00);
		// Sync output: pulse every ratio+1 periods, pin set as output
		ratio = 8'h02;
		soe = 1'b1;
		n = 0;
		for (k = 0; k < 12; k++) begin
			ps = 1'b1;
			cyc(1);
			ps = 1'b0;
			repeat (3) begin
				if (sout === 1'b1) n++;
				cyc(1);
			end
		end
		chk(8'(n), 8'h04);
		end_sim();
	end
endmodule
